// File: design/flash_regs_pkg.sv
// constants for the flash led driver register bank and its serial slave
//Operation
//- answer only slave address 0x63
//- direction bit zero writes, one reads
//- write bytes are index then data
//- registers load listed defaults on reset
//- enable bit 7 gates rf sync pin
//- enable bit 6 picks level or edge strobe
//- bit 5 strobe pin, bit 4 torch pin
//- mode 00 standby 01 ir 10 torch 11 flash
//- led enable field off 00, on 11
//- monitor bit 6 enables undervoltage lockout
//- threshold code 2.9 to 3.6 V, hysteresis bit
//- action field selects current adjustment style
//- action bits change only while idle
//- six bit flash current code, default 111111
//- seven bit torch code, bit 7 one
//- boost bit 7 write causes software reset
//- boost bits 3..0 short, pass, frequency, limit
//- temperature bit 6 sets torch polarity
//- bits 5 and 4 thermistor fault enables
//- thermistor threshold code, default 100
//- temperature bit 0 picks torch or thermistor
//- acknowledge received bytes, not sent bytes
//- reading first flag register clears it
package flash_regs_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h63;
    localparam logic [7:0] IDX_ENABLE = 8'h01;
    localparam logic [7:0] IDX_MONITOR = 8'h02;
    localparam logic [7:0] IDX_FLASH = 8'h03;
    localparam logic [7:0] IDX_TORCH = 8'h05;
    localparam logic [7:0] IDX_BOOST = 8'h07;
    localparam logic [7:0] IDX_TIMING = 8'h08;
    localparam logic [7:0] IDX_THERM = 8'h09;
    localparam logic [7:0] IDX_FAULT_FLAGS_FIRST = 8'h0a;
    localparam logic [7:0] IDX_FLAGS2 = 8'h0b;
    localparam logic [7:0] IDX_IDENT = 8'h0c;
    localparam logic [7:0] IDX_LAST = 8'h0d;
    localparam logic [7:0] RST_ENABLE = 8'h80;
    localparam logic [7:0] RST_MONITOR = 8'h01;
    localparam logic [7:0] RST_FLASH = 8'hbf;
    localparam logic [7:0] RST_TORCH = 8'hbf;
    localparam logic [7:0] RST_BOOST = 8'h09;
    localparam logic [7:0] RST_TIMING = 8'h1a;
    localparam logic [7:0] RST_THERM = 8'h08;
    // writable and status bit masks, reserved bits zero
    localparam logic [7:0] MSK_ENABLE = 8'hff;
    localparam logic [7:0] MSK_MONITOR = 8'h7f;
    localparam logic [7:0] MSK_BOOST = 8'h0f;
    localparam logic [7:0] MSK_THERM = 8'h7f;
    localparam logic [7:0] MSK_FLAGS2 = 8'h1f;
    localparam logic [7:0] MSK_LAST = 8'h7f;
    localparam int BIT_SW_RESET = 7;
    localparam logic [1:0] MODE_STANDBY = 2'b00;
    localparam logic [1:0] MODE_IR = 2'b01;
    localparam logic [1:0] MODE_TORCH = 2'b10;
    localparam logic [1:0] MODE_FLASH = 2'b11;
    localparam logic [1:0] LED_OFF = 2'b00;
    localparam logic [1:0] LED_ON = 2'b11;
    // arbitrary identity value
    localparam logic [7:0] IDENT_VALUE = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b011,
        ST_DATA = 3'b010,
        ST_SEND = 3'b110,
        ST_RACK = 3'b111
    } slave_state_e;
endpackage : flash_regs_pkg

// File: design/flash_led_driver_regs.sv
// serial slave and register bank of the flash led driver
`timescale 1ns/100ps
module flash_led_driver_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status from the analog side
    input wire logic [7:0] fault_fault_flags_first_set,
    input wire logic [7:0] fault_flags2_set,
    input wire logic [6:0] applied_flash_code,
    input wire logic device_active,
    // decoded controls
    output logic rf_sync_enable,
    output logic strobe_edge,
    output logic strobe_pin_enable,
    output logic torch_pin_enable,
    output logic [1:0] operating_mode_bits,
    output logic [1:0] led_enable,
    output logic undervoltage_lockout_enable,
    output logic [2:0] monitor_threshold,
    output logic monitor_hysteresis,
    output logic [1:0] monitor_action,
    output logic [5:0] flash_code,
    output logic [6:0] torch_code,
    output logic short_detect_enable,
    output logic pass_mode_only,
    output logic freq_4mhz,
    output logic limit_high,
    output logic [7:0] timing_value,
    output logic torch_active_low,
    output logic thermistor_open_enable,
    output logic thermistor_short_enable,
    output logic [2:0] thermistor_threshold,
    output logic thermistor_select
);
    // input synchronisers, three stages
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
            if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
            if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
        end
    end

    // settled pin edges and bus conditions
    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_now = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
    assign sda_now = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    assign scl_rise = scl_now & ~scl_q;
    assign scl_fall = ~scl_now & scl_q;
    assign start_cond = scl_q & scl_now & sda_q & ~sda_now;
    assign stop_cond = scl_q & scl_now & ~sda_q & sda_now;

    // register storage
    logic [7:0] enable_control_q;
    logic [7:0] voltage_monitor_config_q;
    logic [7:0] flash_current_level_q;
    logic [7:0] torch_current_level_q;
    logic [7:0] boost_config_q;
    logic [7:0] timing_config_q;
    logic [7:0] thermistor_config_q;
    logic [7:0] fault_flags_first_q;
    logic [7:0] fault_flags_second_q;
    logic [7:0] last_applied_flash_code_q;

    // slave state
    flash_regs_pkg::slave_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] index_q;
    logic have_index_q;
    logic reading_q;
    logic nack_q;
    logic wr_stb;
    logic rd_stb;
    logic soft_rst;
    logic any_rst;
    assign soft_rst = wr_stb && index_q == flash_regs_pkg::IDX_BOOST && shift_q[flash_regs_pkg::BIT_SW_RESET];
    assign any_rst = sys_rst | soft_rst;

    // read data mux, unmapped indices read zero
    logic [7:0] rd_data;
    always_comb begin
        case (index_q)
            flash_regs_pkg::IDX_ENABLE: rd_data = enable_control_q;
            flash_regs_pkg::IDX_MONITOR: rd_data = voltage_monitor_config_q;
            flash_regs_pkg::IDX_FLASH: rd_data = flash_current_level_q;
            flash_regs_pkg::IDX_TORCH: rd_data = torch_current_level_q;
            flash_regs_pkg::IDX_BOOST: rd_data = boost_config_q;
            flash_regs_pkg::IDX_TIMING: rd_data = timing_config_q;
            flash_regs_pkg::IDX_THERM: rd_data = thermistor_config_q;
            flash_regs_pkg::IDX_FAULT_FLAGS_FIRST: rd_data = fault_flags_first_q;
            flash_regs_pkg::IDX_FLAGS2: rd_data = fault_flags_second_q;
            flash_regs_pkg::IDX_IDENT: rd_data = flash_regs_pkg::IDENT_VALUE;
            flash_regs_pkg::IDX_LAST: rd_data = last_applied_flash_code_q;
            default: rd_data = 8'h00;
        endcase
    end

    // byte level state machine
    always_ff @(posedge clk) begin
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        if (sys_rst) begin
            state_q <= flash_regs_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 8'h00;
            have_index_q <= 1'b0;
            reading_q <= 1'b0;
            nack_q <= 1'b0;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            state_q <= flash_regs_pkg::ST_ADDR;
            bit_cnt_q <= 4'h0;
            have_index_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state_q <= flash_regs_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state_q)
                flash_regs_pkg::ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                flash_regs_pkg::ST_ADDR, flash_regs_pkg::ST_DATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_now};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == flash_regs_pkg::ST_ADDR) begin
                            if (shift_q[7:1] == flash_regs_pkg::SLAVE_ADDR) begin
                                reading_q <= shift_q[0];
                                state_q <= flash_regs_pkg::ST_ACK;
                                sda_out <= 1'b0;
                                sda_oe <= 1'b1;
                            end else begin
                                state_q <= flash_regs_pkg::ST_IDLE;
                            end
                        end else begin
                            state_q <= flash_regs_pkg::ST_ACK;
                            sda_out <= 1'b0;
                            sda_oe <= 1'b1;
                            if (!have_index_q) begin
                                index_q <= shift_q;
                                have_index_q <= 1'b1;
                            end else begin
                                wr_stb <= 1'b1;
                            end
                        end
                    end
                end
                flash_regs_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (reading_q) begin
                            state_q <= flash_regs_pkg::ST_SEND;
                            shift_q <= {rd_data[6:0], 1'b0};
                            sda_out <= rd_data[7];
                            sda_oe <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                            rd_stb <= 1'b1;
                        end else begin
                            state_q <= flash_regs_pkg::ST_DATA;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                flash_regs_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            state_q <= flash_regs_pkg::ST_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_out <= shift_q[7];
                            sda_oe <= ~shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                flash_regs_pkg::ST_RACK: begin
                    // master ack on the ninth rise moves to the next index
                    if (scl_rise) begin
                        nack_q <= sda_now;
                        if (!sda_now) index_q <= index_q + 8'h01;
                    end
                    if (scl_fall) begin
                        if (nack_q) begin
                            state_q <= flash_regs_pkg::ST_IDLE;
                            sda_oe <= 1'b0;
                        end else begin
                            // next byte's msb goes out on this same fall
                            state_q <= flash_regs_pkg::ST_SEND;
                            shift_q <= {rd_data[6:0], 1'b0};
                            sda_out <= rd_data[7];
                            sda_oe <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                            rd_stb <= 1'b1;
                        end
                    end
                end
                default: state_q <= flash_regs_pkg::ST_IDLE;
            endcase
        end
    end

    // control register writes, defaults on either reset
    always_ff @(posedge clk) begin
        if (any_rst) begin
            enable_control_q <= flash_regs_pkg::RST_ENABLE;
            voltage_monitor_config_q <= flash_regs_pkg::RST_MONITOR;
            flash_current_level_q <= flash_regs_pkg::RST_FLASH;
            torch_current_level_q <= flash_regs_pkg::RST_TORCH;
            boost_config_q <= flash_regs_pkg::RST_BOOST;
            timing_config_q <= flash_regs_pkg::RST_TIMING;
            thermistor_config_q <= flash_regs_pkg::RST_THERM;
        end else if (wr_stb) begin
            case (index_q)
                flash_regs_pkg::IDX_ENABLE: enable_control_q <= shift_q;
                flash_regs_pkg::IDX_MONITOR: begin
                    // action bits held while active
                    if (device_active) begin
                        voltage_monitor_config_q <= {shift_q[7:2] & flash_regs_pkg::MSK_MONITOR[7:2],
                                                     voltage_monitor_config_q[1:0]};
                    end else begin
                        voltage_monitor_config_q <= shift_q & flash_regs_pkg::MSK_MONITOR;
                    end
                end
                flash_regs_pkg::IDX_FLASH: flash_current_level_q <= shift_q;
                flash_regs_pkg::IDX_TORCH: torch_current_level_q <= shift_q;
                flash_regs_pkg::IDX_BOOST: boost_config_q <= shift_q & flash_regs_pkg::MSK_BOOST;
                flash_regs_pkg::IDX_TIMING: timing_config_q <= shift_q;
                flash_regs_pkg::IDX_THERM: thermistor_config_q <= shift_q & flash_regs_pkg::MSK_THERM;
                default: ;
            endcase
        end
    end

    // fault flags, set wins over read clear
    logic rd_fault_flags_first;
    assign rd_fault_flags_first = rd_stb && index_q == flash_regs_pkg::IDX_FAULT_FLAGS_FIRST;
    always_ff @(posedge clk) begin
        if (any_rst) begin
            fault_flags_first_q <= 8'h00;
            fault_flags_second_q <= 8'h00;
            last_applied_flash_code_q <= 8'h00;
        end else begin
            fault_flags_first_q <= (rd_fault_flags_first ? 8'h00 : fault_flags_first_q) | fault_fault_flags_first_set;
            fault_flags_second_q <= fault_flags_second_q | (fault_flags2_set & flash_regs_pkg::MSK_FLAGS2);
            last_applied_flash_code_q <= {1'b0, applied_flash_code} & flash_regs_pkg::MSK_LAST;
        end
    end

    // decoded control outputs, registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rf_sync_enable <= 1'b0;
            strobe_edge <= 1'b0;
            strobe_pin_enable <= 1'b0;
            torch_pin_enable <= 1'b0;
            operating_mode_bits <= flash_regs_pkg::MODE_STANDBY;
            led_enable <= flash_regs_pkg::LED_OFF;
            undervoltage_lockout_enable <= 1'b0;
            monitor_threshold <= 3'h0;
            monitor_hysteresis <= 1'b0;
            monitor_action <= 2'h0;
            flash_code <= 6'h00;
            torch_code <= 7'h00;
            short_detect_enable <= 1'b0;
            pass_mode_only <= 1'b0;
            freq_4mhz <= 1'b0;
            limit_high <= 1'b0;
            timing_value <= 8'h00;
            torch_active_low <= 1'b0;
            thermistor_open_enable <= 1'b0;
            thermistor_short_enable <= 1'b0;
            thermistor_threshold <= 3'h0;
            thermistor_select <= 1'b0;
        end else begin
            rf_sync_enable <= enable_control_q[7];
            strobe_edge <= enable_control_q[6];
            strobe_pin_enable <= enable_control_q[5];
            torch_pin_enable <= enable_control_q[4];
            operating_mode_bits <= enable_control_q[3:2];
            // illegal codes treated as off
            led_enable <= (enable_control_q[1:0] == flash_regs_pkg::LED_ON) ? flash_regs_pkg::LED_ON
                                                                            : flash_regs_pkg::LED_OFF;
            undervoltage_lockout_enable <= voltage_monitor_config_q[6];
            monitor_threshold <= voltage_monitor_config_q[5:3];
            monitor_hysteresis <= voltage_monitor_config_q[2];
            monitor_action <= voltage_monitor_config_q[1:0];
            flash_code <= flash_current_level_q[5:0];
            torch_code <= torch_current_level_q[6:0];
            short_detect_enable <= boost_config_q[3];
            pass_mode_only <= boost_config_q[2];
            freq_4mhz <= boost_config_q[1];
            limit_high <= boost_config_q[0];
            timing_value <= timing_config_q;
            torch_active_low <= thermistor_config_q[6];
            thermistor_open_enable <= thermistor_config_q[5];
            thermistor_short_enable <= thermistor_config_q[4];
            thermistor_threshold <= thermistor_config_q[3:1];
            thermistor_select <= thermistor_config_q[0];
        end
    end

    // checks
    rst_defaults_a: assert property (@(posedge clk) $past(sys_rst) |-> enable_control_q == 8'h80
        && flash_current_level_q == 8'hbf && timing_config_q == 8'h1a) else $error("reset default wrong");
    addr_match_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == flash_regs_pkg::ST_ADDR && $past(state_q) == flash_regs_pkg::ST_ADDR ##1
        state_q == flash_regs_pkg::ST_ACK && $past(state_q) == flash_regs_pkg::ST_ADDR)
        |-> $past(shift_q[7:1], 2) == 7'h63) else $error("ack for foreign address");
    ack_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == flash_regs_pkg::ST_ACK && !reading_q) |-> (sda_oe && !sda_out)) else $error("no ack drive");
    no_read_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == flash_regs_pkg::ST_RACK |-> !sda_oe) else $error("acked own byte");
    soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        soft_rst |=> boost_config_q == 8'h09 && enable_control_q == 8'h80) else $error("soft reset missed");
    flags_clear_a: assert property (@(posedge clk) disable iff (any_rst)
        rd_fault_flags_first |=> fault_flags_first_q == $past(fault_fault_flags_first_set)) else $error("flags not cleared");
    action_hold_a: assert property (@(posedge clk) disable iff (any_rst)
        (wr_stb && device_active) |=> $stable(voltage_monitor_config_q[1:0])) else $error("action changed");
    reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        boost_config_q[6:4] == 3'h0 && voltage_monitor_config_q[7] == 1'b0 && !thermistor_config_q[7])
        else $error("reserved bit set");
    mode_track_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##2 operating_mode_bits == $past(enable_control_q[3:2])) else $error("mode decode stale");
    // led field only ever leaves as off or on
    led_legal_a: assert property (@(posedge clk) disable iff (sys_rst)
        led_enable == flash_regs_pkg::LED_OFF || led_enable == flash_regs_pkg::LED_ON)
        else $error("led code illegal");
    // a foreign address drops back to idle with the line released
    addr_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == flash_regs_pkg::ST_ADDR && scl_fall && bit_cnt_q == 4'h8
        && shift_q[7:1] != flash_regs_pkg::SLAVE_ADDR)
        |=> (state_q == flash_regs_pkg::ST_IDLE && !sda_oe)) else $error("foreign address taken");
    // main scenarios
    wr_cov: cover property (@(posedge clk) wr_stb && index_q == flash_regs_pkg::IDX_ENABLE);
    foreign_cov: cover property (@(posedge clk) state_q == flash_regs_pkg::ST_ADDR && scl_fall
        && bit_cnt_q == 4'h8 && shift_q[7:1] != flash_regs_pkg::SLAVE_ADDR);
    burst_cov: cover property (@(posedge clk) state_q == flash_regs_pkg::ST_RACK && scl_fall && !nack_q);
    rd_cov: cover property (@(posedge clk) rd_fault_flags_first);
    srst_cov: cover property (@(posedge clk) soft_rst);
endmodule : flash_led_driver_regs

// File: test/host_model.sv
// serial bus host model that drives the link pins of the register bank
`timescale 1ns/100ps
module host_model (
    // clock and wire level
    input wire logic clk,
    input wire logic sda_line,
    // driven pins
    output logic scl,
    output logic sda_low
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // a quarter of the 80 ns link period, moves on falling clk
    task automatic half;
        repeat (2) @(negedge clk);
    endtask : half
    // start or repeated start, data falls while clock is high
    task automatic start;
        sda_low = 1'b0;
        half;
        scl = 1'b1;
        half;
        sda_low = 1'b1;
        half;
        scl = 1'b0;
        half;
    endtask : start
    // one clock pulse; data set while clock low, sampled mid high
    task automatic one_bit(input logic b, output logic r);
        sda_low = ~b;
        half;
        scl = 1'b1;
        half;
        r = sda_line;
        half;
        scl = 1'b0;
        half;
    endtask : one_bit
    // eight bits msb first, then the ninth pulse with data released or driven
    task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            one_bit(tx[i], rx[i]);
        end
        one_bit(nine, ack);
    endtask : xfer
    // stop: data rises while clock is high, then the line is released
    task automatic stop;
        sda_low = 1'b1;
        half;
        scl = 1'b1;
        half;
        sda_low = 1'b0;
        half;
        half;
    endtask : stop
endmodule : host_model

// File: test/tb.sv
// self-checking bench for the flash led driver register bank
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb;
    logic clk, sys_rst, scl, sda_low, sda_out, sda_oe, act;
    logic [7:0] f1, f2, rx;
    logic [6:0] code;
    logic [1:0] mode, led, act_o;
    logic [5:0] fl;
    logic [6:0] tq, mon, th;
    logic [3:0] bst;
    logic [7:0] en, tv;
    int n_fail = 0;
    int n_checks = 0;
    // wire-and of both drivers over the pull-up
    wire sda_line = ~(sda_low | (sda_oe & ~sda_out));
    host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    flash_led_driver_regs i_dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .fault_fault_flags_first_set(f1), .fault_flags2_set(f2),
        .applied_flash_code(code), .device_active(act), .rf_sync_enable(en[7]), .strobe_edge(en[6]),
        .strobe_pin_enable(en[5]), .torch_pin_enable(en[4]), .operating_mode_bits(mode), .led_enable(led),
        .undervoltage_lockout_enable(mon[6]), .monitor_threshold(mon[5:3]), .monitor_hysteresis(mon[2]),
        .monitor_action(act_o), .flash_code(fl), .torch_code(tq), .short_detect_enable(bst[3]),
        .pass_mode_only(bst[2]), .freq_4mhz(bst[1]), .limit_high(bst[0]), .timing_value(tv),
        .torch_active_low(th[6]), .thermistor_open_enable(th[5]), .thermistor_short_enable(th[4]),
        .thermistor_threshold(th[3:1]), .thermistor_select(th[0]));
    assign mon[1:0] = act_o;
    assign en[3:0] = {mode, led};
    // verdict and end of run
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // register write: address with write bit, index, data
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic a;
        i_host.start;
        i_host.xfer({flash_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
        `CHK(a, 1'b0)
        i_host.xfer(idx, 1'b1, rx, a);
        i_host.xfer(val, 1'b1, rx, a);
        `CHK(a, 1'b0)
        i_host.stop;
    endtask : wr
    // register read through repeated start, host ends with no-ack
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic a;
        i_host.start;
        i_host.xfer({flash_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
        i_host.xfer(idx, 1'b1, rx, a);
        i_host.start;
        i_host.xfer({flash_regs_pkg::SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
        `CHK(a, 1'b0)
        i_host.xfer(8'hff, 1'b1, rx, a);
        i_host.stop;
        `CHK(rx, exp)
    endtask : rc
    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
    // main sequence
    initial begin
        logic [7:0] ix [11] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
        logic [7:0] dv [11] = '{8'h80, 8'h01, 8'hbf, 8'hbf, 8'h09, 8'h1a, 8'h08, 8'h00, 8'h00,
            flash_regs_pkg::IDENT_VALUE, 8'h55};
        logic a;
        sys_rst = 1'b1;
        f1 = 8'h00;
        f2 = 8'h00;
        code = 7'h55;
        act = 1'b0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 11; i++) rc(ix[i], dv[i]);
        `CHK({en, bst, mon, th, tq, tv}, {8'h80, 4'h9, 7'h01, 7'h08, 7'h3f, 8'h1a})
        i_host.start;
        i_host.xfer(8'hc4, 1'b1, rx, a);
        i_host.stop;
        `CHK(a, 1'b1)
        for (int m = 0; m < 4; m++) begin
            wr(8'h01, {((m == 1) ? 4'h3 : 4'h7), m[1:0], 2'b11});
            `CHK({en[7:4], mode, led}, {((m == 1) ? 4'h3 : 4'h7), m[1:0], 2'b11})
            wr(8'h01, {6'h00, {2{m[0]}}});
            `CHK(led, {2{m[0]}})
        end
        wr(8'h02, 8'hff);
        rc(8'h02, 8'h7f);
        `CHK(mon, 7'h7f)
        act = 1'b1;
        wr(8'h02, 8'h00);
        act = 1'b0;
        rc(8'h02, 8'h03);
        wr(8'h03, 8'haa);
        wr(8'h05, 8'hd5);
        `CHK({fl, tq}, {6'h2a, 7'h55})
        wr(8'h07, 8'h7a);
        rc(8'h07, 8'h0a);
        wr(8'h09, 8'hff);
        rc(8'h09, 8'h7f);
        `CHK({bst, th}, {4'ha, 7'h7f})
        wr(8'h04, 8'h55);
        rc(8'h04, 8'h00);
        f1 = 8'h04;
        f2 = 8'hff;
        repeat (3) @(negedge clk);
        f1 = 8'h00;
        f2 = 8'h00;
        rc(8'h0a, 8'h04);
        rc(8'h0a, 8'h00);
        rc(8'h0b, 8'h1f);
        wr(8'h07, 8'h80);
        rc(8'h09, 8'h08);
        rc(8'h0b, 8'h00);
        `CHK({en, bst}, {8'h80, 4'h9})
        print_verdict;
    end
endmodule : tb
